// ==== test/fsc_checker.sv ====
// checker: port assertions for the fault status capture block
// assumes it is bound into fsc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module fsc_checker (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_PRIV,
    input wire logic [31:0] REG_RDATA,
    input wire logic REG_ERR,
    // events and requests
    input wire fsc_pkg::fsc_evt_t EVT,
    input wire logic [7:0] CUR_PRIO,
    input wire logic [7:0] BUS_PRIO,
    input wire fsc_pkg::fsc_req_t REQ,
    input wire logic IMPR_PENDING
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RESET);
    a_unpriv_refused: assert property (
        (REG_RD || REG_WR) && !REG_PRIV |=> REG_ERR && REG_RDATA == 32'h0)
        else $error("unprivileged access not refused");
    a_priv_accepted: assert property (
        (REG_RD || REG_WR) && REG_PRIV |=> !REG_ERR)
        else $error("privileged access refused");
    a_prec_capture: assert property (
        EVT.prec_err |=> REQ.bus_req && REQ.ret_at_fault)
        else $error("precise error request missing");
    a_unstack_chain: assert property (
        EVT.unstk_err |=> REQ.keep_frame && !REQ.sp_adjust)
        else $error("unstack error frame handling wrong");
    a_stack_adjust: assert property (
        EVT.stk_err && !EVT.unstk_err |=> REQ.sp_adjust && !REQ.keep_frame)
        else $error("stack error did not adjust pointer");
    a_usage_return: assert property (
        EVT.undef || EVT.inv_state || EVT.inv_pc
        |=> REQ.usage_req && REQ.ret_at_fault)
        else $error("usage fault request missing");
    a_prot_request: assert property (
        EVT.prot_data |=> REQ.prot_req)
        else $error("protection request missing");
    a_impr_pends: assert property (
        EVT.impr_err && CUR_PRIO <= BUS_PRIO |=> IMPR_PENDING && !REQ.bus_req)
        else $error("imprecise error did not pend");
    a_pend_holds: assert property (
        IMPR_PENDING && CUR_PRIO <= BUS_PRIO && !RESET |=> IMPR_PENDING)
        else $error("pending imprecise error lost");
    c_both_flags: cover property (EVT.prec_err && IMPR_PENDING);
    c_refused: cover property (REG_ERR);
    c_activated: cover property ($fell(IMPR_PENDING));
endmodule
bind fsc_top fsc_checker i_chk (.CLOCK(CLOCK), .RESET(RESET),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_PRIV(REG_PRIV),
    .REG_RDATA(REG_RDATA), .REG_ERR(REG_ERR), .EVT(EVT),
    .CUR_PRIO(CUR_PRIO), .BUS_PRIO(BUS_PRIO), .REQ(REQ),
    .IMPR_PENDING(IMPR_PENDING));
`default_nettype wire

// ==== test/fsc_partner.sv ====
// partner: pipeline and bus interfaces reporting fault events
// assumes the bench calls report from its main process
`timescale 1ns/1ps
`default_nettype none
module fsc_partner (
    // clock
    input wire logic clock,
    // fault events
    output fsc_pkg::fsc_evt_t evt
);
    initial evt = '0;
    task report(input fsc_pkg::fsc_evt_t e);
        fsc_pkg::fsc_evt_t idle;
        idle = '0;
        idle.prec_addr = ~e.prec_addr;
        idle.prot_addr = ~e.prot_addr;
        @(posedge clock);
        evt <= e;
        @(posedge clock);
        evt <= idle;
    endtask
endmodule
`default_nettype wire

// ==== test/fsc_top_test.sv ====
// testbench: fault status capture block against its partner
// assumes default parameters of fsc_top
`timescale 1ns/1ps
`default_nettype none
module fsc_top_test;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_priv = 1'b0;
    logic reg_err;
    logic impr_pending;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] cur_prio = 8'h00;
    logic [7:0] bus_prio = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    fsc_pkg::fsc_evt_t evt;
    fsc_pkg::fsc_req_t req;
    fsc_pkg::fsc_evt_t e;
    int n_mismatch = 0;
    int n_tests = 0;
    always #5 clock = ~clock;
    fsc_partner i_far (.clock(clock), .evt(evt));
    fsc_top i_dut (.CLOCK(clock), .RESET(reset), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_PRIV(reg_priv), .REG_RDATA(reg_rdata), .REG_ERR(reg_err),
        .EVT(evt), .CUR_PRIO(cur_prio), .BUS_PRIO(bus_prio), .REQ(req),
        .IMPR_PENDING(impr_pending));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic p);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        reg_priv <= p;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic p, input logic [31:0] x);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        reg_priv <= p;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, x);
        check({31'h0, reg_err}, {31'h0, ~p});
    endtask
    task t_reset_priv;
        for (int i = 0; i < 5; i++) rdchk(8'(i * 4), 1'b1, 32'h0);
        wr(fsc_pkg::OFS_CONF, 32'h18, 1'b0);
        rdchk(fsc_pkg::OFS_CONF, 1'b0, 32'h0);
        rdchk(fsc_pkg::OFS_CONF, 1'b1, 32'h0);
    endtask
    task t_bus;
        e = '0;
        e.prec_err = 1'b1;
        e.prec_addr = 32'hA5A5_0010;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h24);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h0000_8200);
        rdchk(fsc_pkg::OFS_BADDR, 1'b1, 32'hA5A5_0010);
        e = '0;
        e.prot_data = 1'b1;
        e.prot_addr = 32'h5A5A_0020;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h0C);
        rdchk(fsc_pkg::OFS_PFAR, 1'b1, 32'h5A5A_0020);
        wr(fsc_pkg::OFS_COMB, 32'hFFFF_FFFF, 1'b1);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h0);
        e = '0;
        e.pf_issue_err = 1'b1;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h24);
        e = '0;
        e.unstk_err = 1'b1;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h21);
        e = '0;
        e.stk_err = 1'b1;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h22);
        e = '0;
        e.lsp_err = 1'b1;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h20);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h0000_3900);
        rdchk(fsc_pkg::OFS_BADDR, 1'b1, 32'hA5A5_0010);
        wr(fsc_pkg::OFS_COMB, 32'hFFFF_FFFF, 1'b1);
    endtask
    task t_imprecise;
        @(posedge clock);
        cur_prio <= 8'h01;
        bus_prio <= 8'h08;
        e = '0;
        e.impr_err = 1'b1;
        e.impr_src = 5'h08;
        e.impr_resp = 2'h2;
        i_far.report(e);
        #1 check({31'h0, impr_pending}, 32'h1);
        check({26'h0, req}, 32'h0);
        e = '0;
        e.prec_err = 1'b1;
        e.prec_addr = 32'h0000_0F00;
        i_far.report(e);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h0000_8600);
        rdchk(fsc_pkg::OFS_ABFS, 1'b1, 32'h0000_0208);
        wr(fsc_pkg::OFS_ABFS, 32'h0, 1'b1);
        rdchk(fsc_pkg::OFS_ABFS, 1'b1, 32'h0000_0200);
        @(posedge clock);
        cur_prio <= 8'h09;
        @(posedge clock);
        #1 check({26'h0, req}, 32'h20);
        check({31'h0, impr_pending}, 32'h0);
        wr(fsc_pkg::OFS_COMB, 32'hFFFF_FFFF, 1'b1);
    endtask
    task t_usage;
        e = '0;
        e.undef = 1'b1;
        i_far.report(e);
        e = '0;
        e.inv_state = 1'b1;
        i_far.report(e);
        #1 check({26'h0, req}, 32'h14);
        e = '0;
        e.inv_pc = 1'b1;
        i_far.report(e);
        e = '0;
        e.no_cp = 1'b1;
        e.unalign = 1'b1;
        e.div_zero = 1'b1;
        i_far.report(e);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h000F_0000);
        e.unalign_multi = 1'b1;
        i_far.report(e);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h010F_0000);
        wr(fsc_pkg::OFS_CONF, 32'h18, 1'b1);
        wr(fsc_pkg::OFS_COMB, 32'h0100_0000, 1'b1);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h000F_0000);
        e = '0;
        e.unalign = 1'b1;
        e.div_zero = 1'b1;
        i_far.report(e);
        rdchk(fsc_pkg::OFS_COMB, 1'b1, 32'h030F_0000);
    endtask
    task finish_test;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        t_reset_priv;
        t_bus;
        t_imprecise;
        t_usage;
        finish_test;
    end
    initial begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        finish_test;
    end
endmodule
`default_nettype wire

// ==== verilog/fsc_pkg.sv ====
// package for the fault status capture block
// assumes one core clock and a plain register port
package fsc_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_COMB = 8'h00;
    localparam logic [7:0] OFS_PFAR = 8'h04;
    localparam logic [7:0] OFS_BADDR = 8'h08;
    localparam logic [7:0] OFS_ABFS = 8'h0C;
    localparam logic [7:0] OFS_CONF = 8'h10;
    // combined status word fields
    localparam int PROT_LSB = 0;
    localparam int BUS_LSB = 8;
    localparam int USE_LSB = 16;
    // protection status bit
    localparam int PAV_BIT = 7;
    // bus status bits
    localparam int IBE_BIT = 0;
    localparam int PDE_BIT = 1;
    localparam int IDE_BIT = 2;
    localparam int USE_BIT = 3;
    localparam int SKE_BIT = 4;
    localparam int LSP_BIT = 5;
    localparam int BAV_BIT = 7;
    // usage status bits
    localparam int UND_BIT = 0;
    localparam int IVS_BIT = 1;
    localparam int IPC_BIT = 2;
    localparam int NCP_BIT = 3;
    localparam int UNA_BIT = 8;
    localparam int DVZ_BIT = 9;
    // aux source register fields
    localparam int SRC_W = 5;
    localparam int RTYPE_LSB = 8;
    localparam int MAIN_SRC_BIT = 3;
    // config register bits
    localparam int UTRP_BIT = 3;
    localparam int DTRP_BIT = 4;
    // reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [4:0] RST_SRC = 5'h00;
    localparam logic [1:0] RST_RT = 2'h0;
    localparam logic [7:0] RST_PRI = 8'h00;

    // fault events from pipeline and bus interfaces
    typedef struct packed {
        logic pf_issue_err;
        logic prec_err;
        logic [31:0] prec_addr;
        logic impr_err;
        logic [4:0] impr_src;
        logic [1:0] impr_resp;
        logic unstk_err;
        logic stk_err;
        logic lsp_err;
        logic prot_data;
        logic [31:0] prot_addr;
        logic undef;
        logic inv_state;
        logic inv_pc;
        logic no_cp;
        logic unalign;
        logic unalign_multi;
        logic div_zero;
    } fsc_evt_t;

    // requests to the exception logic
    typedef struct packed {
        logic bus_req;
        logic usage_req;
        logic prot_req;
        logic ret_at_fault;
        logic sp_adjust;
        logic keep_frame;
    } fsc_req_t;

    // register port response
    typedef struct packed {
        logic [31:0] rdata;
        logic err;
    } fsc_rsp_t;

    // whole state of the block
    typedef struct packed {
        logic [7:0] prot_st;
        logic [7:0] bus_st;
        logic [15:0] use_st;
        logic [31:0] pfar;
        logic [31:0] baddr;
        logic [4:0] src;
        logic [1:0] rtype;
        logic utrp;
        logic dtrp;
        logic pend;
        fsc_req_t req;
        fsc_rsp_t rsp;
    } fsc_state_t;
endpackage

// ==== verilog/fsc_top.sv ====
// fault status and fault address capture
// assumes synchronous inputs, one clock, privileged-tagged register port
`timescale 1ns/1ps
`default_nettype none
module fsc_top #(
    parameter bit HAS_FPU = 1'b1,
    parameter bit SHARED_ADDR = 1'b0
) (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic REG_PRIV,
    output logic [31:0] REG_RDATA,
    output logic REG_ERR,
    // fault events and priorities
    input wire fsc_pkg::fsc_evt_t EVT,
    input wire logic [7:0] CUR_PRIO,
    input wire logic [7:0] BUS_PRIO,
    // requests to exception logic
    output fsc_pkg::fsc_req_t REQ,
    output logic IMPR_PENDING
);

    fsc_pkg::fsc_state_t s_r;
    fsc_pkg::fsc_state_t s_nxt;

    // ************************************************
    // helpers
    // ************************************************
    function automatic logic [31:0] comb_word(
        input fsc_pkg::fsc_state_t s);
        comb_word = {s.use_st, s.bus_st, s.prot_st};
    endfunction

    function automatic logic hit(input logic [7:0] a,
        input logic [7:0] o);
        hit = (a == o);
    endfunction

    logic acc;
    logic ok;
    logic bad;
    logic [31:0] w1c;
    logic bus_lo;
    logic unal;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        s_nxt = s_r;
        acc = REG_WR | REG_RD;
        ok = acc & REG_PRIV;
        bad = acc & ~REG_PRIV;
        w1c = (REG_WR & ok & hit(REG_ADDR, fsc_pkg::OFS_COMB)) ?
            REG_WDATA : 32'h0000_0000;
        bus_lo = (CUR_PRIO > BUS_PRIO);
        unal = EVT.unalign & (s_r.utrp | EVT.unalign_multi);
        s_nxt.req = '0;
        s_nxt.rsp.err = bad;
        s_nxt.rsp.rdata = 32'h0000_0000;

        // software clears first so hardware sets win
        s_nxt.prot_st = s_r.prot_st & ~w1c[fsc_pkg::BUS_LSB-1:0];
        s_nxt.bus_st = s_r.bus_st &
            ~w1c[fsc_pkg::USE_LSB-1:fsc_pkg::BUS_LSB];
        s_nxt.use_st = s_r.use_st & ~w1c[31:fsc_pkg::USE_LSB];

        if (REG_WR && ok) begin
            if (hit(REG_ADDR, fsc_pkg::OFS_PFAR)) begin
                s_nxt.pfar = REG_WDATA;
            end else if (hit(REG_ADDR, fsc_pkg::OFS_BADDR)) begin
                s_nxt.baddr = REG_WDATA;
            end else if (hit(REG_ADDR, fsc_pkg::OFS_ABFS)) begin
                s_nxt.src = fsc_pkg::RST_SRC;
            end else if (hit(REG_ADDR, fsc_pkg::OFS_CONF)) begin
                s_nxt.utrp = REG_WDATA[fsc_pkg::UTRP_BIT];
                s_nxt.dtrp = REG_WDATA[fsc_pkg::DTRP_BIT];
            end
        end

        if (REG_RD && ok) begin
            if (hit(REG_ADDR, fsc_pkg::OFS_COMB)) begin
                s_nxt.rsp.rdata = comb_word(s_r);
            end else if (hit(REG_ADDR, fsc_pkg::OFS_PFAR)) begin
                s_nxt.rsp.rdata = s_r.pfar;
            end else if (hit(REG_ADDR, fsc_pkg::OFS_BADDR)) begin
                s_nxt.rsp.rdata = SHARED_ADDR ? s_r.pfar
                    : s_r.baddr;
            end else if (hit(REG_ADDR, fsc_pkg::OFS_ABFS)) begin
                s_nxt.rsp.rdata[fsc_pkg::SRC_W-1:0] = s_r.src;
                s_nxt.rsp.rdata[fsc_pkg::RTYPE_LSB+:2] = s_r.rtype;
            end else if (hit(REG_ADDR, fsc_pkg::OFS_CONF)) begin
                s_nxt.rsp.rdata[fsc_pkg::UTRP_BIT] = s_r.utrp;
                s_nxt.rsp.rdata[fsc_pkg::DTRP_BIT] = s_r.dtrp;
            end
        end

        // protection data fault
        if (EVT.prot_data) begin
            s_nxt.prot_st[fsc_pkg::PAV_BIT] = 1'b1;
            s_nxt.pfar = EVT.prot_addr;
            s_nxt.req.prot_req = 1'b1;
            s_nxt.req.ret_at_fault = 1'b1;
            if (SHARED_ADDR) begin
                s_nxt.bus_st[fsc_pkg::BAV_BIT] = 1'b0;
            end
        end

        // bus faults
        if (EVT.pf_issue_err) begin
            s_nxt.bus_st[fsc_pkg::IBE_BIT] = 1'b1;
            s_nxt.req.bus_req = 1'b1;
            s_nxt.req.ret_at_fault = 1'b1;
        end
        if (EVT.prec_err) begin
            s_nxt.bus_st[fsc_pkg::PDE_BIT] = 1'b1;
            s_nxt.bus_st[fsc_pkg::BAV_BIT] = 1'b1;
            if (SHARED_ADDR) begin
                s_nxt.pfar = EVT.prec_addr;
                s_nxt.prot_st[fsc_pkg::PAV_BIT] = 1'b0;
            end else begin
                s_nxt.baddr = EVT.prec_addr;
            end
            s_nxt.req.bus_req = 1'b1;
            s_nxt.req.ret_at_fault = 1'b1;
        end
        if (EVT.unstk_err) begin
            s_nxt.bus_st[fsc_pkg::USE_BIT] = 1'b1;
            s_nxt.req.bus_req = 1'b1;
            s_nxt.req.keep_frame = 1'b1;
        end
        if (EVT.stk_err) begin
            s_nxt.bus_st[fsc_pkg::SKE_BIT] = 1'b1;
            s_nxt.req.bus_req = 1'b1;
            s_nxt.req.sp_adjust = 1'b1;
        end
        if (EVT.lsp_err && HAS_FPU) begin
            s_nxt.bus_st[fsc_pkg::LSP_BIT] = 1'b1;
            s_nxt.req.bus_req = 1'b1;
        end

        // imprecise error pends while outranked
        if (EVT.impr_err) begin
            s_nxt.bus_st[fsc_pkg::IDE_BIT] = 1'b1;
            s_nxt.src = s_nxt.src | EVT.impr_src;
            if (EVT.impr_src[fsc_pkg::MAIN_SRC_BIT]) begin
                s_nxt.rtype = EVT.impr_resp;
            end
        end
        if ((EVT.impr_err || s_r.pend) && bus_lo) begin
            s_nxt.req.bus_req = 1'b1;
            s_nxt.pend = 1'b0;
        end else if (EVT.impr_err) begin
            s_nxt.pend = 1'b1;
        end

        // usage faults
        if (EVT.undef) begin
            s_nxt.use_st[fsc_pkg::UND_BIT] = 1'b1;
        end
        if (EVT.inv_state) begin
            s_nxt.use_st[fsc_pkg::IVS_BIT] = 1'b1;
        end
        if (EVT.inv_pc) begin
            s_nxt.use_st[fsc_pkg::IPC_BIT] = 1'b1;
        end
        if (EVT.no_cp) begin
            s_nxt.use_st[fsc_pkg::NCP_BIT] = 1'b1;
        end
        if (unal) begin
            s_nxt.use_st[fsc_pkg::UNA_BIT] = 1'b1;
        end
        if (EVT.div_zero && s_r.dtrp) begin
            s_nxt.use_st[fsc_pkg::DVZ_BIT] = 1'b1;
        end
        if (EVT.undef || EVT.inv_state || EVT.inv_pc || EVT.no_cp
            || unal || (EVT.div_zero && s_r.dtrp)) begin
            s_nxt.req.usage_req = 1'b1;
            s_nxt.req.ret_at_fault = 1'b1;
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            s_r.prot_st <= fsc_pkg::RST_BYTE;
            s_r.bus_st <= fsc_pkg::RST_BYTE;
            s_r.use_st <= fsc_pkg::RST_HALF;
            s_r.pfar <= fsc_pkg::RST_WORD;
            s_r.baddr <= fsc_pkg::RST_WORD;
            s_r.src <= fsc_pkg::RST_SRC;
            s_r.rtype <= fsc_pkg::RST_RT;
            s_r.utrp <= 1'b0;
            s_r.dtrp <= 1'b0;
            s_r.pend <= 1'b0;
            s_r.req <= '0;
            s_r.rsp <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    assign REG_RDATA = s_r.rsp.rdata;
    assign REG_ERR = s_r.rsp.err;
    assign REQ = s_r.req;
    assign IMPR_PENDING = s_r.pend;

endmodule
`default_nettype wire
